/* shared/fid_consts.svh */
// constants for the fourteen-bit instruction decoder
`ifndef FID_CONSTS_SVH
`define FID_CONSTS_SVH
`define FID_GRP_MSB 13
`define FID_GRP_LSB 12
`define FID_DEST_BIT 7
`define FID_FILE_MSB 6
`define FID_BIT_MSB 9
`define FID_BIT_LSB 7
`define FID_K8_MSB 7
`define FID_K11_MSB 10
`define FID_GOTO_BIT 11
`define FID_SLEEP_WORD 14'h0063
`define FID_WDOG_CLEAR_WORD 14'h0064
`define FID_RETURN_WORD 14'h0008
`define FID_INT_RETURN_WORD 14'h0009
`define FID_TIMER_ZERO_ADDR 7'h01
`define FID_PC_LOW_ADDR 7'h02
`define FID_PHASES 2'h3
`define FID_NOP_WORD 14'h0000
`endif

/* shared/fid_pkg.sv */
// types for the fourteen-bit instruction decoder
package fid_pkg;
  typedef enum logic [1:0] {FID_BYTE, FID_BIT, FID_LIT} fid_group_e;
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_AND, OP_CLR, OP_COM, OP_DEC, OP_DECSZ, OP_INC,
    OP_INCSZ, OP_IOR, OP_MOV, OP_MOVW, OP_RL, OP_RR, OP_SUB, OP_SWAP,
    OP_XOR
  } fid_op_e;
  typedef struct packed {
    fid_group_e group;
    logic [4:0] op;
    logic dest_file;
    logic [6:0] file_addr;
    logic [2:0] bit_pos;
    logic [10:0] literal;
    logic lit_wide;
    logic sleep;
    logic wdog_clear;
    logic pc_change;
    logic cond;
    logic src_pins;
    logic clr_prescale;
  } fid_dec_s;
endpackage

/* design/fid_decoder.sv */
// fourteen-bit instruction decoder and cycle sequencer
`timescale 1ns/10ps
`include "fid_consts.svh"

// Operation
// (RULE1) each instruction is one fourteen-bit word
// (RULE2) classify into byte, bit, literal groups
// (RULE3) destination bit zero accumulator, one file
// (RULE4) file operand addresses 0x00 to 0x7f
// (RULE5) bit operand picks one of eight
// (RULE6) literal is eight or eleven bits
// (RULE7) don't-care opcode bits are ignored
// (RULE8) one cycle, two when skip or branch
// (RULE9) instruction cycle is four oscillator periods
// (RULE10) standby word decoded, touches status bits; the code only raises dec.sleep and sleep_pulse and holds no status bits
// (RULE11) self-modify of port uses pin value
// (RULE12) timer zero write clears assigned prescaler
// (RULE13) top two bits select group
module fid_decoder
  import fid_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // program memory
  input wire logic [13:0] instr_word,
  // execution feedback
  input wire logic cond_true,
  input wire logic file_is_port,
  input wire logic prescale_on_timer,
  // decoded instruction, held for the cycle
  output fid_dec_s dec,
  // sequencing
  output logic [1:0] phase,
  output logic fetch,
  output logic flush_nop,
  output logic clr_prescale_pulse,
  output logic sleep_pulse
);
  fid_dec_s dec_d;
  fid_dec_s dec_q;
  logic [1:0] phase_q;
  logic fetch_q;
  logic flush_q;
  logic flush_next_q;
  logic clrp_q;
  logic sleep_q;
  logic last_phase;

  assign last_phase = (phase_q == `FID_PHASES);

  // byte op selector from bits 11..8
  function automatic logic [4:0] byte_op(input logic [3:0] s, input logic d);
    case (s)
      4'h0: byte_op = d ? OP_MOVW : OP_NONE;
      4'h1: byte_op = OP_CLR;
      4'h2: byte_op = OP_SUB;
      4'h3: byte_op = OP_DEC;
      4'h4: byte_op = OP_IOR;
      4'h5: byte_op = OP_AND;
      4'h6: byte_op = OP_XOR;
      4'h7: byte_op = OP_ADD;
      4'h8: byte_op = OP_MOV;
      4'h9: byte_op = OP_COM;
      4'ha: byte_op = OP_INC;
      4'hb: byte_op = OP_DECSZ;
      4'hc: byte_op = OP_RR;
      4'hd: byte_op = OP_RL;
      4'he: byte_op = OP_SWAP;
      default: byte_op = OP_INCSZ;
    endcase
  endfunction

  // combinational split of the word into fields
  always_comb
  begin
    dec_d = '0;
    dec_d.file_addr = instr_word[`FID_FILE_MSB:0]; // RULE4
    dec_d.dest_file = instr_word[`FID_DEST_BIT]; // RULE3
    dec_d.bit_pos = instr_word[`FID_BIT_MSB:`FID_BIT_LSB]; // RULE5
    case (instr_word[`FID_GRP_MSB:`FID_GRP_LSB]) // RULE13
      2'b00:
      begin
        dec_d.group = FID_BYTE; // RULE2
        dec_d.op = byte_op(instr_word[11:8], instr_word[`FID_DEST_BIT]);
        // clear and store forms also take bit seven as destination
        dec_d.sleep = (instr_word == `FID_SLEEP_WORD); // RULE10
        dec_d.wdog_clear = (instr_word == `FID_WDOG_CLEAR_WORD);
        dec_d.pc_change = (instr_word == `FID_RETURN_WORD) ||
          (instr_word == `FID_INT_RETURN_WORD) ||
          (dec_d.dest_file && dec_d.file_addr == `FID_PC_LOW_ADDR &&
           dec_d.op != OP_NONE);
        dec_d.cond = (dec_d.op == OP_DECSZ) || (dec_d.op == OP_INCSZ);
        // read-modify of a port reads the pins, not the latch
        dec_d.src_pins = file_is_port && dec_d.op != OP_NONE &&
          dec_d.op != OP_MOVW && dec_d.op != OP_CLR; // RULE11
        dec_d.clr_prescale = prescale_on_timer && dec_d.dest_file &&
          dec_d.op != OP_NONE &&
          dec_d.file_addr == `FID_TIMER_ZERO_ADDR; // RULE12
      end
      2'b01:
      begin
        dec_d.group = FID_BIT; // RULE2
        dec_d.cond = instr_word[11];
        dec_d.src_pins = file_is_port && !instr_word[11]; // RULE11
        dec_d.clr_prescale = prescale_on_timer && !instr_word[11] &&
          dec_d.file_addr == `FID_TIMER_ZERO_ADDR; // RULE12
        dec_d.pc_change = !instr_word[11] &&
          dec_d.file_addr == `FID_PC_LOW_ADDR;
      end
      default:
      begin
        dec_d.group = FID_LIT; // RULE2
        dec_d.dest_file = 1'b0;
        if (!instr_word[12])
        begin
          // call or goto carry eleven bits
          dec_d.literal = instr_word[`FID_K11_MSB:0]; // RULE6
          dec_d.lit_wide = 1'b1;
          dec_d.pc_change = 1'b1;
        end
        else
        begin
          // bits 9..8 don't care; only bits 11..10 used
          dec_d.literal = {3'h0, instr_word[`FID_K8_MSB:0]}; // RULE6 RULE7
          dec_d.pc_change = (instr_word[11:10] == 2'b01);
        end
      end
    endcase
  end

  // oscillator phase counter, four per instruction
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1; // RULE9
  end

  // latch word at the start of each instruction cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      dec_q <= '0;
    else if (last_phase)
    begin
      if (flush_next_q)
        dec_q <= '0; // RULE8
      else
        dec_q <= dec_d; // RULE1
    end
  end

  // second cycle of skip or branch becomes a no-operation
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flush_next_q <= 1'b0;
      flush_q <= 1'b0;
    end
    else if (last_phase)
    begin
      flush_q <= flush_next_q;
      flush_next_q <= !flush_next_q &&
        (dec_d.pc_change || (dec_d.cond && cond_true)); // RULE8
    end
  end

  // one-clock strobes at the start of each cycle; prescaler and sleep strobes only for an executed cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fetch_q <= 1'b0;
      clrp_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      fetch_q <= last_phase;
      clrp_q <= last_phase && !flush_next_q && dec_d.clr_prescale;
      sleep_q <= last_phase && !flush_next_q && dec_d.sleep; // RULE10
    end
  end

  assign dec = dec_q;
  assign phase = phase_q;
  assign fetch = fetch_q;
  assign flush_nop = flush_q;
  assign clr_prescale_pulse = clrp_q;
  assign sleep_pulse = sleep_q;

  // fetch strobe every fourth clock
  property p_fetch_period;
    @(posedge clk) disable iff (reset)
      fetch |=> !fetch ##1 !fetch ##1 !fetch ##1 fetch;
  endproperty
  a_fetch_period: assert property (p_fetch_period) // RULE9
    else $error("fetch period is not four clocks");

  // branch leads to a flushed next cycle
  property p_branch_flush;
    @(posedge clk) disable iff (reset)
      (last_phase && !flush_next_q && dec_d.pc_change) |=> ##4 flush_nop;
  endproperty
  a_branch_flush: assert property (p_branch_flush) // RULE8
    else $error("branch not followed by nop cycle");

  // flushed cycle holds a cleared instruction
  property p_flush_empty;
    @(posedge clk) disable iff (reset)
      flush_nop |-> dec.op == OP_NONE && !dec.pc_change;
  endproperty
  a_flush_empty: assert property (p_flush_empty) // RULE8
    else $error("nop cycle carries an operation");

  // top bits pick the group
  property p_group;
    @(posedge clk) disable iff (reset)
      (last_phase && !flush_next_q) |=>
        dec.group == (($past(instr_word[13]) ? FID_LIT :
        ($past(instr_word[12]) ? FID_BIT : FID_BYTE)));
  endproperty
  a_group: assert property (p_group) // RULE13
    else $error("group mismatch");

  // sleep strobe only for the standby word
  property p_sleep;
    @(posedge clk) disable iff (reset)
      sleep_pulse |-> $past(instr_word) == `FID_SLEEP_WORD;
  endproperty
  a_sleep: assert property (p_sleep) // RULE10
    else $error("sleep strobe on wrong word");

  // prescaler clear only for timer zero address
  property p_prescale;
    @(posedge clk) disable iff (reset)
      clr_prescale_pulse |->
        $past(instr_word[6:0]) == `FID_TIMER_ZERO_ADDR &&
        $past(prescale_on_timer);
  endproperty
  a_prescale: assert property (p_prescale) // RULE12
    else $error("prescaler clear on wrong target");

  // destination follows bit seven for byte ops
  property p_dest;
    @(posedge clk) disable iff (reset)
      (last_phase && !flush_next_q && instr_word[13:12] == 2'b00) |=>
        dec.dest_file == $past(instr_word[7]);
  endproperty
  a_dest: assert property (p_dest) // RULE3
    else $error("destination bit mismatch");

  // short literal is the low byte of the word, zero above
  property p_literal;
    @(posedge clk) disable iff (reset)
      (last_phase && !flush_next_q && instr_word[13:12] == 2'b11) |=>
        !dec.lit_wide && dec.literal == {3'h0, $past(instr_word[7:0])};
  endproperty
  a_literal: assert property (p_literal) // RULE6
    else $error("short literal has high bits");
endmodule

/* bench/fid_prog_model.sv */
// program memory model feeding words to the decoder
`timescale 1ns/10ps
module fid_prog_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fetch strobe and queued word
  input wire logic fetch,
  input wire logic [13:0] next_word,
  input wire logic next_cond,
  // word to the decoder
  output logic [13:0] instr_word,
  output logic cond_true
);
  // word changes only on fetch, so it holds to the sample edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      instr_word <= 14'h0000;
      cond_true <= 1'b0;
    end
    else if (fetch)
    begin
      instr_word <= next_word;
      cond_true <= next_cond;
    end
  end
endmodule

/* bench/tb_fid_decoder.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tb_fid_decoder;
  import fid_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] instr_word, next_word = 14'h0000;
  logic cond_true, next_cond = 1'b0;
  logic file_is_port = 1'b0;
  logic prescale_on_timer = 1'b0;
  fid_dec_s dec;
  logic [1:0] phase;
  logic fetch, flush_nop, clr_prescale_pulse, sleep_pulse;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  fid_prog_model u_mem (.clk(clk), .reset(reset), .fetch(fetch),
    .next_word(next_word), .next_cond(next_cond),
    .instr_word(instr_word), .cond_true(cond_true));
  fid_decoder u_dut (.clk(clk), .reset(reset), .instr_word(instr_word),
    .cond_true(cond_true), .file_is_port(file_is_port),
    .prescale_on_timer(prescale_on_timer), .dec(dec), .phase(phase),
    .fetch(fetch), .flush_nop(flush_nop),
    .clr_prescale_pulse(clr_prescale_pulse), .sleep_pulse(sleep_pulse));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, far above the roughly 160 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    num_checks++;
    if (exp !== got)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // queue one word at a fetch, return just after its decode edge
  task automatic run(input logic [13:0] w, input logic c = 1'b0,
    input logic p = 1'b0, input logic t = 1'b0);
    int n = 0;
    @(negedge clk);
    while (fetch !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    next_word = w;
    next_cond = c;
    @(posedge clk);
    file_is_port <= p;
    prescale_on_timer <= t;
    repeat (3) @(posedge clk);
    #1;
    chk("phase", 16'h0, phase);
    chk("fetch", 16'h1, fetch);
  endtask
  // add with accumulator destination at file 0x00 and file destination at file 0x7f
  task automatic t_byte;
    for (int d = 0; d < 2; d++)
    begin
      run({2'b00, 4'h7, d[0], d[0] ? 7'h7f : 7'h00});
      chk("group", FID_BYTE, dec.group);
      chk("op", OP_ADD, dec.op);
      chk("dest", 16'(d), dec.dest_file);
      chk("file", d ? 16'h7f : 16'h0, dec.file_addr);
    end
  endtask
  // bit set on every bit position
  task automatic t_bit;
    for (int b = 0; b < 8; b++)
    begin
      run({4'h5, b[2:0], 7'h55});
      chk("group", FID_BIT, dec.group);
      chk("bit", 16'(b), dec.bit_pos);
    end
  endtask
  // byte literal with every don't-care pattern
  task automatic t_lit;
    for (int x = 0; x < 4; x++)
    begin
      run({4'hc, x[1:0], 8'ha5});
      chk("group", FID_LIT, dec.group);
      chk("lit", 16'ha5, dec.literal[7:0]);
      chk("wide", 16'h0, dec.lit_wide);
    end
  endtask
  // jump flushes one slot; skip flushes only when true
  task automatic t_branch;
    run(14'h2fa5);
    chk("lit", 16'h7a5, dec.literal);
    chk("wide", 16'h1, dec.lit_wide);
    chk("pcchg", 16'h1, dec.pc_change);
    run(14'h0000);
    chk("flush", 16'h1, flush_nop);
    chk("dec", 16'h0, {15'h0, |dec});
    // return and literal return also alter the counter
    for (int r = 0; r < 2; r++)
    begin
      run(r[0] ? 14'h3755 : 14'h0008);
      chk("ret", 16'h1, dec.pc_change);
      run(14'h0000);
      chk("rflush", 16'h1, flush_nop);
    end
    // decrement-skip and bit-test skip, condition false then true
    for (int c = 0; c < 4; c++)
    begin
      run(c[1] ? {4'h7, 3'h0, 7'h20} : 14'h0ba0, c[0]);
      chk("cond", 16'h1, dec.cond);
      run(14'h0000);
      chk("skip", 16'(c[0]), flush_nop);
    end
  endtask
  // standby word, then a plain word
  task automatic t_sleep;
    run(14'h0063);
    chk("sleep", 16'h1, sleep_pulse);
    chk("dsleep", 16'h1, dec.sleep);
    run(14'h0000);
    chk("sleep0", 16'h0, sleep_pulse);
    run(14'h0064);
    chk("wdog", 16'h1, dec.wdog_clear);
    chk("sleep1", 16'h0, sleep_pulse);
  endtask
  // port self-modify source and timer write prescaler clear
  task automatic t_side;
    for (int i = 0; i < 2; i++)
    begin
      run(14'h08c6, 1'b0, i[0]);
      chk("pins", 16'(i), dec.src_pins);
      run(14'h0081, 1'b0, 1'b0, i[0]);
      chk("clrpre", 16'(i), clr_prescale_pulse);
      chk("dclrpre", 16'(i), dec.clr_prescale);
      run(14'h0681, 1'b0, 1'b0, i[0]);
      chk("xorpre", 16'(i), clr_prescale_pulse);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_byte();
    t_bit();
    t_lit();
    t_branch();
    t_sleep();
    t_side();
    end_sim();
  end
endmodule
